// ### design/gtc_timer_block.sv
// three gated 16-bit timer/counters behind an avalon-mm slave
//
// Overview of operation
// - 16-bit up counter read as two bytes; a byte write loads it at once.
// - internal clock makes it a timer, one step per prescaled clock.
// - external input counts rising edges, synchronised or asynchronous.
// - off when on bit clear; on alone always counts; with gate enable gate decides.
// - clock select 11 low-frequency osc, 10 external pin, 01 system, 00 system/4.
// - system clock gives four counts per instruction cycle, two-LSB read uncertainty.
// - external mode needs a falling edge before first rising edge after enable or write.
// - two-bit prescale field divides the count clock by 1, 2, 4 or 8.
// - prescaler hidden from software and cleared by any counter byte write.
// - oscillator enable starts the crystal oscillator, which keeps running in sleep.
// - sync-disable bit counts the external input without synchronising it.
// - asynchronous external counting continues in sleep and its overflow can wake.
// - switching sync mode may lose or add a single increment.
// - three identical timer instances.
// - count wraps FFFFh to 0000h and sets a software-cleared overflow flag.
// - gated with gate inactive, the counter holds its value.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module gtc_timer_block (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // pins, one per timer, plus the low-frequency oscillator shared by all three
    input wire logic [gtc_pkg::NUM_TIMERS-1:0] EXT_COUNT_INPUT,
    input wire logic [gtc_pkg::NUM_TIMERS-1:0] CRYSTAL_IN_PIN,
    input wire logic [gtc_pkg::NUM_TIMERS-1:0] GATE_IN,
    input wire logic LOW_FREQ_INTERNAL_OSC,
    // power state and oscillator control
    input wire logic SLEEP,
    output logic [gtc_pkg::NUM_TIMERS-1:0] CRYSTAL_OSC_ENABLE,
    // interrupt
    output logic IRQ
);
    import gtc_pkg::*;

    localparam int NSYNC = 3 * NUM_TIMERS + 1;

    logic ack_q;
    logic req;
    logic wr_acc;
    logic rd_take;
    logic [31:0] readdata_q;
    logic [31:0] rd_mux;
    logic [1:0] div_q;
    logic instr_tick;
    logic [NSYNC-1:0] pin_s1_q;
    logic [NSYNC-1:0] pin_s2_q;
    logic [NSYNC-1:0] pin_s3_q;
    logic [NSYNC-1:0] pin_lvl_q;
    ctrl_t ctrl_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] gate_en_q;
    logic [NUM_TIMERS-1:0] status_q;
    logic [NUM_TIMERS-1:0] mask_q;
    logic [NUM_TIMERS-1:0] ovf;
    logic [15:0] count [NUM_TIMERS];
    count_wr_t cwr [NUM_TIMERS];

    // timer index and register slot of a byte address
    function automatic logic [1:0] tmr_index(input logic [7:0] addr);
        tmr_index = addr[5:4];
    endfunction : tmr_index

    function automatic logic [7:0] tmr_slot(input logic [7:0] addr);
        tmr_slot = {4'h0, addr[3:0]};
    endfunction : tmr_slot

    // one wait state on every access; read data is registered as ack rises, a write acts on the edge that ends the ack cycle
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign wr_acc = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
    assign rd_take = AVS_READ & ~ack_q;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // three-stage pin synchronisers; a level is taken once stages two and three agree
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_lvl_q <= '0;
        end else begin
            pin_s1_q <= {LOW_FREQ_INTERNAL_OSC, GATE_IN, CRYSTAL_IN_PIN, EXT_COUNT_INPUT};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
        end
    end

    // instruction clock strobe, system clock divided by four
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_q <= 2'h0;
        end else if (!SLEEP) begin
            div_q <= div_q + 2'h1;
        end
    end
    assign instr_tick = (div_q == INSTR_DIV_LAST) & ~SLEEP;

    generate
        for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
            localparam logic [7:0] BASE = 8'(i * 16);
            src_lvl_t src;

            assign src.ext_count_input = pin_lvl_q[i];
            assign src.crystal_in_pin = pin_lvl_q[NUM_TIMERS + i];
            assign src.gate = pin_lvl_q[2 * NUM_TIMERS + i];
            assign src.low_freq_internal_osc = pin_lvl_q[3 * NUM_TIMERS];
            assign cwr[i].wr_low = wr_acc && AVS_ADDRESS == BASE + OFS_COUNT_LOW;
            assign cwr[i].wr_high = wr_acc && AVS_ADDRESS == BASE + OFS_COUNT_HIGH;
            assign cwr[i].data = AVS_WRITEDATA[7:0];
            // oscillator enable is independent of sleep
            assign CRYSTAL_OSC_ENABLE[i] = ctrl_q[i].sec_osc_enable;

            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    ctrl_q[i] <= ctrl_t'(CTRL_RESET);
                end else if (wr_acc && AVS_ADDRESS == BASE + OFS_TIMER_CTRL) begin
                    ctrl_q[i] <= ctrl_t'(AVS_WRITEDATA[CTRL_WIDTH-1:0]);
                end
            end

            always_ff @(posedge CORE_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    gate_en_q[i] <= 1'b0;
                end else if (wr_acc && AVS_ADDRESS == BASE + OFS_GATE_CTRL) begin
                    gate_en_q[i] <= AVS_WRITEDATA[GATE_EN_BIT];
                end
            end

            gtc_counter u_counter (
                .clk(CORE_CLK),
                .rst_n(RESET_N),
                .ctrl(ctrl_q[i]),
                .gate_count_enable(gate_en_q[i]),
                .src(src),
                .instr_tick(instr_tick),
                .sleep(SLEEP),
                .wr(cwr[i]),
                .count(count[i]),
                .overflow(ovf[i])
            );
        end
    endgenerate

    // overflow flags: set beats a same-cycle write-one clear
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status_q <= '0;
        end else if (wr_acc && AVS_ADDRESS == OFS_IRQ_STATUS) begin
            status_q <= (status_q & ~AVS_WRITEDATA[NUM_TIMERS-1:0]) | ovf;
        end else begin
            status_q <= status_q | ovf;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask_q <= IRQ_MASK_RESET;
        end else if (wr_acc && AVS_ADDRESS == OFS_IRQ_MASK) begin
            mask_q <= AVS_WRITEDATA[NUM_TIMERS-1:0];
        end
    end

    // level interrupt, also the wake request while asleep
    assign IRQ = |(status_q & mask_q);

    // read decode ignores address bits 7:6, so timer registers repeat above 3Fh; other unmapped addresses read zero
    always_comb begin
        logic [1:0] idx;
        logic [7:0] slot;
        idx = tmr_index(AVS_ADDRESS);
        slot = tmr_slot(AVS_ADDRESS);
        rd_mux = 32'h0000_0000;
        if (AVS_ADDRESS == OFS_IRQ_STATUS) begin
            rd_mux[NUM_TIMERS-1:0] = status_q;
        end else if (AVS_ADDRESS == OFS_IRQ_MASK) begin
            rd_mux[NUM_TIMERS-1:0] = mask_q;
        end else if (idx < 2'(NUM_TIMERS) && slot == OFS_COUNT_LOW) begin
            rd_mux[7:0] = count[idx][7:0];
        end else if (idx < 2'(NUM_TIMERS) && slot == OFS_COUNT_HIGH) begin
            rd_mux[7:0] = count[idx][15:8];
        end else if (idx < 2'(NUM_TIMERS) && slot == OFS_TIMER_CTRL) begin
            rd_mux[CTRL_WIDTH-1:0] = ctrl_q[idx];
        end else if (idx < 2'(NUM_TIMERS) && slot == OFS_GATE_CTRL) begin
            rd_mux[GATE_EN_BIT] = gate_en_q[idx];
            rd_mux[GATE_VAL_BIT] = pin_lvl_q[2 * NUM_TIMERS + 32'(idx)];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            readdata_q <= rd_mux;
        end
    end
    assign AVS_READDATA = readdata_q;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    property p_one_wait;
        req && !ack_q |-> AVS_WAITREQUEST ##1 (!req || !AVS_WAITREQUEST);
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait state");
    property p_flag_set;
        ovf[0] |=> status_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow did not set its flag");
    property p_flag_clear;
        wr_acc && AVS_ADDRESS == OFS_IRQ_STATUS && AVS_WRITEDATA[1] && !ovf[1] |=> !status_q[1];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear flag");
    property p_flag_sticky;
        status_q[2] && !(wr_acc && AVS_ADDRESS == OFS_IRQ_STATUS) |=> status_q[2];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a clear");
    property p_instr_rate;
        instr_tick |=> !instr_tick [*3];
    endproperty
    a_instr_rate: assert property (p_instr_rate) else $error("instruction strobe too fast");
    property p_osc_sleep;
        SLEEP && !(wr_acc && tmr_slot(AVS_ADDRESS) == OFS_TIMER_CTRL)
            |=> CRYSTAL_OSC_ENABLE == $past(CRYSTAL_OSC_ENABLE);
    endproperty
    a_osc_sleep: assert property (p_osc_sleep) else $error("oscillator enable changed in sleep");

    c_overflow: cover property (ovf[0]);
    c_irq: cover property (IRQ && SLEEP);
    c_read_count: cover property (AVS_READ && ack_q && AVS_ADDRESS == OFS_COUNT_HIGH);
    c_ext_async: cover property (ctrl_q[1].count_clock_select == CS_EXTERNAL && ctrl_q[1].sync_disable && ovf[1]);
endmodule : gtc_timer_block

// ### inc/gtc_pkg.sv
// shared constants and types for the gated 16-bit timer/counter block
package gtc_pkg;
    localparam int NUM_TIMERS = 3;
    // register map, byte addresses on the avalon slave
    localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h08;
    localparam logic [7:0] OFS_GATE_CTRL = 8'h0C;
    localparam logic [7:0] TIMER_STRIDE = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    // field positions
    localparam int CTRL_WIDTH = 7;
    localparam int GATE_EN_BIT = 7;
    localparam int GATE_VAL_BIT = 2;
    // reset values
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // timing: the instruction clock is the core clock divided by four
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int INSTR_CLK_HZ = CORE_CLK_HZ / 4;
    localparam int INSTR_DIV = CORE_CLK_HZ / INSTR_CLK_HZ;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

    typedef enum logic [1:0] {
        CS_INSTR = 2'b00,
        CS_SYSTEM = 2'b01,
        CS_EXTERNAL = 2'b10,
        CS_LOW_FREQ = 2'b11
    } clk_sel_t;

    // timer_control_reg layout, bit 6 down to bit 0
    typedef struct packed {
        clk_sel_t count_clock_select;
        logic [1:0] prescale_select;
        logic sec_osc_enable;
        logic sync_disable;
        logic timer_on_bit;
    } ctrl_t;

    typedef struct packed {
        logic wr_low;
        logic wr_high;
        logic [7:0] data;
    } count_wr_t;

    // synchronised levels that feed one timer
    typedef struct packed {
        logic ext_count_input;
        logic crystal_in_pin;
        logic gate;
        logic low_freq_internal_osc;
    } src_lvl_t;
endpackage : gtc_pkg

// ### design/gtc_counter.sv
// one 16-bit timer/counter with prescaler, clock select and gate
`timescale 1ns/1ps
module gtc_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and sources
    input gtc_pkg::ctrl_t ctrl,
    input wire logic gate_count_enable,
    input gtc_pkg::src_lvl_t src,
    input wire logic instr_tick,
    input wire logic sleep,
    // software access
    input gtc_pkg::count_wr_t wr,
    output logic [15:0] count,
    output logic overflow
);
    import gtc_pkg::*;

    logic [15:0] count_q;
    logic [2:0] pre_q;
    logic arm_q;
    logic ext_prev_q;
    logic lf_prev_q;
    logic tog_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    logic ext_lvl;
    logic run;
    logic awake_ok;
    logic ext_mode;
    logic src_tick;
    logic pre_hit;
    logic pre_tick;
    logic inc;
    logic any_wr;

    function automatic logic [2:0] pre_mask(input logic [1:0] sel);
        pre_mask = 3'((4'h1 << sel) - 4'h1);
    endfunction : pre_mask

    assign any_wr = wr.wr_low | wr.wr_high;
    assign ext_lvl = ctrl.sec_osc_enable ? src.crystal_in_pin : src.ext_count_input;
    assign ext_mode = ctrl.count_clock_select == CS_EXTERNAL;
    assign run = ctrl.timer_on_bit & (~gate_count_enable | src.gate);
    // only the unsynchronised external count survives sleep
    assign awake_ok = ~sleep | (ext_mode & ctrl.sync_disable);

    always_comb begin
        case (ctrl.count_clock_select)
            CS_INSTR: src_tick = instr_tick;
            CS_SYSTEM: src_tick = 1'b1;
            CS_EXTERNAL: src_tick = arm_q & ext_lvl & ~ext_prev_q;
            default: src_tick = src.low_freq_internal_osc & ~lf_prev_q;
        endcase
    end

    assign pre_hit = (pre_q & pre_mask(ctrl.prescale_select)) == pre_mask(ctrl.prescale_select);
    assign pre_tick = src_tick & run & awake_ok & pre_hit;
    // async path counts the prescaled edge directly, sync path after the synchroniser
    assign inc = (ext_mode & ~ctrl.sync_disable) ? (tog_s2_q ^ tog_s3_q) & ~sleep : pre_tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_q <= 1'b0;
            lf_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_lvl;
            lf_prev_q <= src.low_freq_internal_osc;
        end
    end

    // a falling edge must be seen before the first counting rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_q <= 1'b0;
        end else if (any_wr || !ctrl.timer_on_bit) begin
            arm_q <= 1'b0;
        end else if (!ext_lvl && ext_prev_q) begin
            arm_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 3'h0;
        end else if (any_wr) begin
            pre_q <= 3'h0;
        end else if (src_tick && run && awake_ok) begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // prescaled edge carried as a toggle through three stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_q <= 1'b0;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_q <= tog_q ^ pre_tick;
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= COUNT_RESET;
        end else if (any_wr) begin
            if (wr.wr_low) count_q[7:0] <= wr.data;
            if (wr.wr_high) count_q[15:8] <= wr.data;
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign count = count_q;
    assign overflow = inc & ~any_wr & (count_q == COUNT_MAX);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_low_load;
        wr.wr_low |=> count[7:0] == $past(wr.data);
    endproperty
    a_low_load: assert property (p_low_load) else $error("low byte write not loaded");
    property p_off_holds;
        // four quiet cycles flush a synchronised edge still in the toggle pipeline
        (!ctrl.timer_on_bit && !any_wr) [*4] |=> $stable(count);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("counter moved while off");
    property p_gate_holds;
        gate_count_enable && !src.gate && !any_wr && !(ext_mode && !ctrl.sync_disable) |=> count == $past(count);
    endproperty
    a_gate_holds: assert property (p_gate_holds) else $error("counter moved with gate closed");
    property p_wrap;
        overflow |=> count == COUNT_RESET;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
    property p_system_step;
        ctrl.count_clock_select == CS_SYSTEM && ctrl.prescale_select == 2'b00 && run && !sleep && !any_wr
            |=> count == $past(count) + 16'h0001;
    endproperty
    a_system_step: assert property (p_system_step) else $error("system clock did not advance count");
    property p_prescale_clear;
        any_wr |=> pre_q == 3'h0;
    endproperty
    a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared by write");
    property p_unarmed;
        ext_mode && ctrl.sync_disable && !arm_q |-> !inc;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("counted before a falling edge");
    property p_sync_lag;
        pre_tick && ext_mode && !ctrl.sync_disable && !sleep ##1 !sleep ##1 !sleep |-> ##1 inc;
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("synchronised edge lost");
    property p_sleep_hold;
        sleep && !(ext_mode && ctrl.sync_disable) && !any_wr |-> !inc;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");
endmodule : gtc_counter

// ### sim/ext_src_model.sv
// far-side pin model: external count pulses and crystal oscillators
`timescale 1ns/1ps
module ext_src_model (
    // clock
    input wire logic clk,
    // oscillator enables from the block
    input wire logic [2:0] osc_en,
    // pin levels
    output logic [2:0] ext,
    output logic [2:0] xtal
);
    logic [1:0] ph [3];
    initial begin
        ext = 3'h7;
        xtal = 3'h0;
        ph = '{default: 2'h0};
    end
    // crystal swings only while enabled, period eight clocks
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (osc_en[i]) begin
                ph[i] <= ph[i] + 2'h1;
                if (ph[i] == 2'h3) xtal[i] <= ~xtal[i];
            end
        end
    end
    // one frame: each pulse falls then rises; line idles high
    task automatic pulse(input int idx, input int n);
        for (int k = 0; k < n; k++) begin
            ext[idx] <= 1'b0;
            repeat (8) @(posedge clk);
            ext[idx] <= 1'b1;
            repeat (8) @(posedge clk);
        end
    endtask : pulse
endmodule : ext_src_model

// ### sim/tb_top.sv
// self-checking bench for the three gated timer/counters
`timescale 1ns/1ps
module tb_top;
    import gtc_pkg::*;
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic wait_req;
    logic [2:0] ext;
    logic [2:0] xtal;
    logic [2:0] gate_in;
    logic lfo;
    logic sleep;
    logic [2:0] osc_en;
    logic irq;
    int n_fail;
    int check_count;
    int cyc;
    int n;
    int e;
    logic [31:0] q;
    logic [31:0] d;
    logic [15:0] cnt;
    int div[4] = '{4, 1, 0, 16};
    int css[3] = '{0, 1, 3};

    gtc_timer_block u_gtc_timer_block (
        .CORE_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .EXT_COUNT_INPUT(ext), .CRYSTAL_IN_PIN(xtal), .GATE_IN(gate_in), .LOW_FREQ_INTERNAL_OSC(lfo),
        .SLEEP(sleep), .CRYSTAL_OSC_ENABLE(osc_en), .IRQ(irq)
    );
    ext_src_model u_ext_src_model (.clk(clk), .osc_en(osc_en), .ext(ext), .xtal(xtal));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // low-frequency oscillator, period sixteen clocks
    always begin
        repeat (8) @(posedge clk);
        lfo <= ~lfo;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic check_rng(input logic [31:0] got, input int lo, input int hi, input string what);
        check_count++;
        if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_rng
    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic [3:0] b);
        int k;
        k = 0;
        addr <= a;
        wdata <= dv;
        be <= b;
        wr_en <= w;
        rd_en <= ~w;
        @(posedge clk);
        while (wait_req !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (k == 20) begin
            n_fail++;
            complete_run();
        end
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask : bus
    function automatic logic [7:0] ad(input int i, input logic [7:0] o);
        return 8'(i) * TIMER_STRIDE + o;
    endfunction : ad
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        bus(1'b1, a, dv, 4'hF);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    task automatic get_count(input int i);
        rd(ad(i, OFS_COUNT_LOW));
        cnt[7:0] = q[7:0];
        rd(ad(i, OFS_COUNT_HIGH));
        cnt[15:8] = q[7:0];
    endtask : get_count
    task automatic start(input int i, input logic [31:0] ctl);
        wr(ad(i, OFS_COUNT_LOW), 32'h0);
        wr(ad(i, OFS_COUNT_HIGH), 32'h0);
        wr(ad(i, OFS_TIMER_CTRL), ctl);
    endtask : start
    task automatic stop(input int i);
        wr(ad(i, OFS_TIMER_CTRL), 32'h0);
        get_count(i);
    endtask : stop

    initial begin
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        rst_n = 1'b0;
        addr = 8'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0;
        be = 4'h0;
        gate_in = 3'h0;
        lfo = 1'b0;
        sleep = 1'b0;
        void'($urandom(26559));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(ad(i, OFS_TIMER_CTRL));
            check(q, 32'h0, "ctrl reset");
            d = $urandom;
            wr(ad(i, OFS_COUNT_LOW), {24'h0, d[7:0]});
            wr(ad(i, OFS_COUNT_HIGH), {24'h0, d[15:8]});
            get_count(i);
            check(cnt, d[15:0], "byte load");
        end
        rd(OFS_IRQ_MASK);
        check(q, 32'h0, "mask reset");
        bus(1'b1, ad(2, OFS_COUNT_LOW), 32'h5A, 4'h0);
        get_count(2);
        check(cnt, d[15:0], "write without byte enable");
        rd(8'hF0);
        check(q, 32'h0, "unmapped read");
        // internal clocks through every prescale setting
        foreach (css[c]) begin
            for (int ps = 0; ps < 4; ps++) begin
                start(0, (css[c] << 5) | (ps << 3) | 1);
                repeat (640) @(posedge clk);
                stop(0);
                e = 642 / (div[css[c]] << ps);
                check_rng(cnt, e - 2, e + 2, "timer rate");
            end
        end
        d = cnt;
        repeat (50) @(posedge clk);
        get_count(0);
        check(cnt, d[15:0], "off holds");
        wr(ad(0, OFS_GATE_CTRL), 32'h80);
        start(0, 32'h21);
        repeat (200) @(posedge clk);
        stop(0);
        check(cnt, 16'h0, "gate low holds");
        gate_in <= 3'h1;
        repeat (10) @(posedge clk);
        rd(ad(0, OFS_GATE_CTRL));
        check(q[7:0], 8'h84, "gate level");
        start(0, 32'h21);
        repeat (200) @(posedge clk);
        stop(0);
        check_rng(cnt, 200, 205, "gate high counts");
        wr(ad(0, OFS_GATE_CTRL), 32'h0);
        // external pulses: timer 1 asynchronous, timer 2 synchronised
        for (int i = 1; i < 3; i++) begin
            n = 3 + $urandom % 10;
            start(i, (i == 1) ? 32'h43 : 32'h41);
            u_ext_src_model.pulse(i, n);
            repeat (10) @(posedge clk);
            stop(i);
            check(cnt, 16'(n), "pulse count");
        end
        sleep <= 1'b1;
        start(0, 32'h21);
        start(1, 32'h43);
        start(2, 32'h41);
        u_ext_src_model.pulse(1, 5);
        u_ext_src_model.pulse(2, 5);
        repeat (10) @(posedge clk);
        stop(0);
        check(cnt, 16'h0, "sleep timer");
        stop(1);
        check(cnt, 16'h5, "sleep async counts");
        stop(2);
        check(cnt, 16'h0, "sleep sync stops");
        sleep <= 1'b0;
        // crystal stability wait: preset FC00h, flag after 1024 cycles
        wr(OFS_IRQ_STATUS, 32'h7);
        wr(ad(0, OFS_COUNT_HIGH), 32'hFC);
        wr(ad(0, OFS_COUNT_LOW), 32'h00);
        wr(ad(0, OFS_TIMER_CTRL), 32'h47);
        check(osc_en, 3'h1, "osc enable");
        repeat (7992) @(posedge clk);
        rd(OFS_IRQ_STATUS);
        check(q, 32'h0, "flag early");
        sleep <= 1'b1;
        repeat (400) @(posedge clk);
        check(osc_en, 3'h1, "osc in sleep");
        sleep <= 1'b0;
        rd(OFS_IRQ_STATUS);
        check(q, 32'h1, "overflow flag");
        check(irq, 1'b0, "masked irq");
        wr(OFS_IRQ_MASK, 32'h1);
        check(irq, 1'b1, "irq raised");
        wr(OFS_IRQ_STATUS, 32'h1);
        rd(OFS_IRQ_STATUS);
        check(q, 32'h0, "flag cleared");
        check(irq, 1'b0, "irq cleared");
        stop(0);
        complete_run();
    end
endmodule : tb_top
